// file: hdl/rcsr_pkg.sv
// Purpose: shared constants of the reset-cause and low-speed oscillator status block
// Assumes: 32-bit APB data, byte addresses, one aligned word per register
// Notes:   offsets of the interrupt registers sit right after the status word
package rcsr_pkg;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] OFS_CSTS      = 12'h024;
  localparam logic [11:0] OFS_INT_STAT  = 12'h028;
  localparam logic [11:0] OFS_INT_CLR   = 12'h02c;
  localparam logic [11:0] OFS_INT_EN    = 12'h030;

  // ----------------------------------------------------------------------
  // field layout of the status word
  // ----------------------------------------------------------------------
  localparam int          BIT_LSI_EN    = 0;
  localparam int          BIT_LSI_RDY   = 1;
  localparam int          BIT_CAUSE_CLR = 24;
  localparam int          CAUSE_LO      = 26;
  localparam int          NUM_CAUSE     = 6;
  localparam logic [31:0] IRQ_MASK      = 32'hfc00_0002;

  // ----------------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------------
  localparam logic [31:0] CSTS_RESET    = 32'h0c00_0000;
  localparam logic [5:0]  CAUSE_POR     = 6'h03;
  localparam logic        LSI_EN_RESET  = 1'b0;
  localparam logic [31:0] INT_RESET     = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // wait states and synchroniser width
  // ----------------------------------------------------------------------
  localparam int          WAIT_B2B      = 2;
  localparam int          WAIT_MAX      = 3;
  localparam int          SYNC_W        = 7;

endpackage

// file: hdl/rcsr_wait_if.sv
// Purpose: handshake between the register file and its wait-state timer
// Assumes: one clock domain
// Notes:   setup and access mirror the two APB phases
`timescale 1ns/100ps
interface rcsr_wait_if;
  logic setup;
  logic access;
  logic ready;

  // the timer answers ready, the register file reports the bus phase
  modport timer
  (
    input  setup,
    input  access,
    output ready
  );
  modport user
  (
    output setup,
    output access,
    input  ready
  );
endinterface

// file: hdl/rcsr_sync.sv
// Purpose: three-stage synchroniser with agreement filter for foreign levels
// Assumes: inputs are slow levels from other clock or reset domains
// Notes:   stage one is read only by stage two
`timescale 1ns/100ps
module rcsr_sync
#(
  parameter int W = rcsr_pkg::SYNC_W
)
(
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // a bit changes only once stages two and three agree
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      dout <= '0;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      dout <= (s2_r & s3_r) | (dout & (s2_r | s3_r));
    end
  end
endmodule

// file: hdl/rcsr_wait.sv
// Purpose: wait-state timer for back-to-back register accesses
// Assumes: APB phases reported through the wait interface
// Notes:   an isolated access completes without waits
`timescale 1ns/100ps
module rcsr_wait
#(
  parameter int WAITS = rcsr_pkg::WAIT_B2B
)
(
  input  wire logic  core_clk,
  input  wire logic  srst,
  rcsr_wait_if.timer bus
);

  logic [1:0] cnt_r;
  logic       lastDone_r;
  logic       b2b_r;
  wire        waitDone = (cnt_r == 2'(WAITS));

  // refuse wait counts the two-bit counter cannot reach
  if (WAITS < 0 || WAITS > rcsr_pkg::WAIT_MAX)
  begin : g_bad
    $error("rcsr_wait: WAITS out of range");
  end

  // only an access that follows a completion at once pays the waits
  assign bus.ready = bus.access & (~b2b_r | waitDone);

  // count access cycles; the setup cycle records whether it came straight after
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      cnt_r      <= 2'h0;
      lastDone_r <= 1'b0;
      b2b_r      <= 1'b0;
    end
    else
    begin
      lastDone_r <= bus.access & bus.ready;
      if (bus.setup)
      begin
        cnt_r <= 2'h0;
        b2b_r <= lastDone_r;
      end
      else if (bus.access && !waitDone)
      begin
        cnt_r <= cnt_r + 2'h1;
      end
    end
  end
endmodule

// file: hdl/rcsr_top.sv
// Purpose: reset-cause and low-speed internal oscillator status register on APB
// Assumes: srst is the system reset, powerRst the power reset, both synchronous
// Notes:   cause inputs are levels from reset logic outside this clock domain
//
// What this block does
// R1: power reset presents the status word as 0x0c00_0000, pin and power flags set
// R2: system reset clears ordinary bits; cause flags survive it, power reset reloads them to pin and power
// R3: word, half-word and byte access, zero to three waits, waits when back to back
// R4: bit 0 is read-write oscillator enable; one turns it on, zero off
// R5: read-only bit 1 follows the oscillator's stable indication
// R6: writing one to bit 24 clears every cause flag; bit 24 reads back zero
// R7: bit 26 set when the external reset pin resets, kept until cleared
// R8: bit 27 set on power-on or power-down reset, cleared only by bit 24
// R9: bit 28 set on software reset, cleared only by bit 24 or power reset
// R10: bit 29 set on independent watchdog reset, cleared by bit 24
// R11: bit 30 set on window watchdog reset, cleared only by bit 24 or power reset
// R12: bit 31 set on low-power reset, cleared only by bit 24 or power reset
// R13: reserved bits read zero; writing cause bits never sets them
// R14: a cause arriving with a clear write still ends up set
//
// Our own choice: the APB slave port.
`timescale 1ns/100ps
module rcsr_top
#(
  parameter int WAITS = rcsr_pkg::WAIT_B2B
)
(
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        powerRst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        lsiStable,
  input  wire logic        extResetPinSeen,
  input  wire logic        powerOnDownSeen,
  input  wire logic        swResetSeen,
  input  wire logic        indepWdogResetSeen,
  input  wire logic        windowWdogResetSeen,
  input  wire logic        lowPowerResetSeen,
  output logic             lsiOscEnable,
  output logic             irq
);

  // ----------------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------------

  // merge write data into a word under the byte strobes
  function automatic logic [31:0] mergeStrb(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [5:0]  causeFlags_r;
  logic [5:0]  causeFlags_nxt;
  logic [5:0]  causePrev_r;
  logic        low_speed_internal_osc_enable_r;
  logic [31:0] intStat_r;
  logic [31:0] intStat_nxt;
  logic [31:0] intEn_r;
  logic [31:0] prdata_r;
  logic        irq_r;
  logic        lsiRdyPrev_r;
  logic [6:0]  syncIn;
  logic [6:0]  syncOut;

  rcsr_wait_if waitBus ();

  // ----------------------------------------------------------------------
  // synchronisers for foreign levels
  // ----------------------------------------------------------------------

  // only power reset clears them, so a cause held across a system reset is still seen
  assign syncIn = {lsiStable, lowPowerResetSeen, windowWdogResetSeen,
                   indepWdogResetSeen, swResetSeen, powerOnDownSeen,
                   extResetPinSeen};

  rcsr_sync #(.W(rcsr_pkg::SYNC_W)) u_sync
  (
    .core_clk (core_clk),
    .rst      (powerRst),
    .din      (syncIn),
    .dout     (syncOut)
  );

  wire [5:0] causeLvl = syncOut[5:0];
  wire       lsiRdy   = syncOut[6];                             // see R5

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------

  // phases and address decode
  wire setupPh  = psel & ~penable;
  wire accessPh = psel & penable;
  wire hitCsts  = (paddr == rcsr_pkg::OFS_CSTS);
  wire hitStat  = (paddr == rcsr_pkg::OFS_INT_STAT);
  wire hitClr   = (paddr == rcsr_pkg::OFS_INT_CLR);
  wire hitEn    = (paddr == rcsr_pkg::OFS_INT_EN);
  wire mapped   = hitCsts | hitStat | hitClr | hitEn;
  wire done     = accessPh & waitBus.ready;
  wire wrDone   = done & pwrite & mapped;

  // write strobes per register
  wire wrCsts   = wrDone & hitCsts;
  wire wrClr    = wrDone & hitClr;
  wire wrEn     = wrDone & hitEn;

  // oscillator enable sits in byte lane 0, the cause clear in lane 3
  wire lsiWr    = wrCsts & pstrb[0];                            // see R4
  wire causeClr = wrCsts & pstrb[3] & pwdata[rcsr_pkg::BIT_CAUSE_CLR]; // see R6

  // ----------------------------------------------------------------------
  // wait states
  // ----------------------------------------------------------------------

  assign waitBus.setup  = setupPh;
  assign waitBus.access = accessPh;

  rcsr_wait #(.WAITS(WAITS)) u_wait
  (
    .core_clk (core_clk),
    .srst     (srst | powerRst),
    .bus      (waitBus)
  );

  // completion and error answer; unmapped addresses answer with an error
  assign pready  = waitBus.ready;                               // see R3
  assign pslverr = waitBus.ready & ~mapped;
  assign prdata  = prdata_r;

  // ----------------------------------------------------------------------
  // reset-cause flags
  // ----------------------------------------------------------------------

  // a cause counts on the rising edge of its synchronised level
  wire [5:0] causeSet = causeLvl & ~causePrev_r;                // see R7 R8 R9 R10 R11 R12

  // clear first, then set, so an event in the clear cycle survives
  assign causeFlags_nxt = (causeClr ? 6'h00 : causeFlags_r) | causeSet; // see R6 R14

  // system reset leaves the flags alone; the bus never writes ones into them
  always_ff @(posedge core_clk)
  begin
    if (powerRst)
    begin
      causeFlags_r <= rcsr_pkg::CAUSE_POR;                      // see R1 R2
      causePrev_r  <= 6'h00;
    end
    else
    begin
      causeFlags_r <= causeFlags_nxt;                           // see R2 R13
      causePrev_r  <= causeLvl;
    end
  end

  // ----------------------------------------------------------------------
  // oscillator enable
  // ----------------------------------------------------------------------

  // ordinary bit: both resets return it to off
  always_ff @(posedge core_clk)
  begin
    if (srst || powerRst)
    begin
      low_speed_internal_osc_enable_r <= rcsr_pkg::LSI_EN_RESET;                        // see R2
    end
    else if (lsiWr)
    begin
      low_speed_internal_osc_enable_r <= pwdata[rcsr_pkg::BIT_LSI_EN];                  // see R4
    end
  end

  assign lsiOscEnable = low_speed_internal_osc_enable_r;

  // ----------------------------------------------------------------------
  // interrupt status, clear and enable
  // ----------------------------------------------------------------------

  // events share the status-word layout; set beats clear
  wire [31:0] evtVec = {causeSet, 24'h000000, lsiRdy & ~lsiRdyPrev_r, 1'b0};
  wire [31:0] clrVec = wrClr ? mergeStrb(32'h0, pwdata, pstrb) : 32'h0;
  assign intStat_nxt = ((intStat_r & ~clrVec) | evtVec) & rcsr_pkg::IRQ_MASK;

  // status follows the flags in surviving a system reset, so a cause is not lost
  always_ff @(posedge core_clk)
  begin
    if (powerRst)
    begin
      intStat_r    <= rcsr_pkg::INT_RESET;
      lsiRdyPrev_r <= 1'b0;
    end
    else
    begin
      intStat_r    <= intStat_nxt;
      lsiRdyPrev_r <= lsiRdy;
    end
  end

  // enable mask and registered interrupt level
  always_ff @(posedge core_clk)
  begin
    if (srst || powerRst)
    begin
      intEn_r <= rcsr_pkg::INT_RESET;
      irq_r   <= 1'b0;
    end
    else
    begin
      if (wrEn)
      begin
        intEn_r <= mergeStrb(intEn_r, pwdata, pstrb) & rcsr_pkg::IRQ_MASK;
      end
      irq_r <= |(intStat_r & intEn_r);
    end
  end

  assign irq = irq_r;

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------

  // clear bit and reserved bits always read zero
  wire [31:0] cstsRd = {causeFlags_r, 2'b00, 22'h000000,
                        lsiRdy, low_speed_internal_osc_enable_r};                       // see R5 R13
  wire [31:0] rdMux  = hitCsts ? cstsRd    :
                       hitStat ? intStat_r :
                       hitEn   ? intEn_r   : 32'h0;

  // data is captured in the setup cycle and held through the waits
  always_ff @(posedge core_clk)
  begin
    if (srst || powerRst)
    begin
      prdata_r <= 32'h0;
    end
    else if (setupPh)
    begin
      prdata_r <= pwrite ? 32'h0 : rdMux;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------

  default clocking cb @(posedge core_clk);
  endclocking

  default disable iff (srst || powerRst);

  // power reset leaves the documented word
  chk_por_value: assert property (disable iff (1'b0) // see R1
    powerRst |=> (causeFlags_r == rcsr_pkg::CAUSE_POR) && !low_speed_internal_osc_enable_r)
    else $error("power reset value wrong");

  // a lone system reset keeps the flags
  chk_sys_keeps: assert property (disable iff (powerRst) // see R2
    (srst && causeSet == 6'h00) |=> causeFlags_r == $past(causeFlags_r))
    else $error("system reset disturbed cause flags");

  // no access waits more than three cycles
  chk_wait_bound: assert property ( // see R3
    (setupPh ##1 accessPh) |-> ##[0:3] pready)
    else $error("access waited too long");

  // oscillator enable follows a lane 0 write
  chk_lsi_write: assert property ( // see R4
    lsiWr |=> lsiOscEnable == $past(pwdata[0]))
    else $error("oscillator enable not written");

  // a ready edge reaches the interrupt status next cycle
  chk_ready_evt: assert property ( // see R5
    $rose(lsiRdy) |=> intStat_r[rcsr_pkg::BIT_LSI_RDY])
    else $error("ready event missed");

  // clear with no new cause empties all flags
  chk_clear_all: assert property ( // see R6
    (causeClr && causeSet == 6'h00) |=> causeFlags_r == 6'h00)
    else $error("cause clear incomplete");

  // the pin reset flag stays set until cleared
  chk_flag_sticky: assert property ( // see R7
    (causeFlags_r[0] && !causeClr) |=> causeFlags_r[0])
    else $error("pin reset flag dropped");

  // every cause edge lands in its flag
  chk_cause_sets: assert property ( // see R8
    (causeSet != 6'h00) |=> (causeFlags_r & $past(causeSet)) == $past(causeSet))
    else $error("cause edge not recorded");

  // reserved and clear bits read zero
  chk_reserved_zero: assert property ( // see R13
    (done && hitCsts && !pwrite) |-> (prdata[25:2] == 24'h000000))
    else $error("reserved bits read nonzero");

  // set wins over clear
  chk_set_wins: assert property ( // see R14
    (causeClr && causeSet != 6'h00) |=> causeFlags_r == $past(causeSet))
    else $error("cause lost in clear cycle");

  // interrupt follows enabled status one cycle later
  chk_irq_level: assert property (
    (|(intStat_r & intEn_r)) [*2] |-> irq)
    else $error("interrupt not raised");

  // either reset turns the oscillator and the interrupt off
  chk_reset_clears: assert property (disable iff (1'b0) // see R2
    (srst || powerRst) |=> !lsiOscEnable && !irq)
    else $error("reset left enable or interrupt on");

  // a bus write never raises a cause flag
  chk_write_no_set: assert property ( // see R13
    (wrCsts && causeSet == 6'h00) |=> (causeFlags_r & ~$past(causeFlags_r)) == 6'h00)
    else $error("write set a cause flag");

  // the low-power flag stays set until cleared
  chk_lp_sticky: assert property ( // see R12
    (causeFlags_r[5] && !causeClr) |=> causeFlags_r[5])
    else $error("low-power flag dropped");

endmodule

// file: verification/tb_top.sv
// Purpose: self-checking bench for the reset-cause and oscillator status block
// Assumes: default wait setting; bench acts as APB master on rising edges
// Notes:   a monitor pops expected results off a queue as each transfer completes
`timescale 1ns/100ps
module tb_top;
  typedef struct {logic [31:0] d; logic e; logic b2b;} rcsr_exp_s;
  logic        core_clk, srst, powerRst, psel, penable, pwrite, lsiStable;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, expStat, rnd;
  logic [3:0]  pstrb;
  logic        pready, pslverr, lsiOscEnable, irq, lastHold;
  logic [5:0]  causeIn, expFlags;
  int          miscompares, n_compared, waits;
  rcsr_exp_s   expQ[$];
  rcsr_exp_s   mx;

  rcsr_top dut
  (
    .core_clk(core_clk), .srst(srst), .powerRst(powerRst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lsiStable(lsiStable), .extResetPinSeen(causeIn[0]),
    .powerOnDownSeen(causeIn[1]), .swResetSeen(causeIn[2]),
    .indepWdogResetSeen(causeIn[3]), .windowWdogResetSeen(causeIn[4]),
    .lowPowerResetSeen(causeIn[5]), .lsiOscEnable(lsiOscEnable), .irq(irq)
  );

  // ----------------------------------------------------------------------
  // clock, checks and closing
  // ----------------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL %0t: read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_bit(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("FAIL %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // generous span; the whole sequence needs well under a thousand cycles
  initial
  begin
    #50000;
    miscompares++;
    stop_test();
  end

  // ----------------------------------------------------------------------
  // bus master and monitor
  // ----------------------------------------------------------------------
  // hold keeps psel up so the next setup follows the completion at once
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
                     input logic [3:0] s, input logic [31:0] ex, input logic er,
                     input logic hold);
    rcsr_exp_s x;
    x.d = ex;
    x.e = er;
    x.b2b = lastHold;
    lastHold = hold;
    expQ.push_back(x);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    if (!hold)
    begin
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge core_clk);
    end
  endtask

  // release the bus after a held transfer when no access follows at once
  task automatic park;
    psel     <= 1'b0;
    penable  <= 1'b0;
    lastHold = 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ex, input logic er,
                    input logic hold);
    apb(a, 1'b0, 32'h0000_0000, 4'h0, ex, er, hold);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic er);
    apb(a, 1'b1, d, s, 32'h0000_0000, er, 1'b1);
  endtask

  // a cause level held well past the two-clock minimum, then settled
  task automatic pulse(input int i);
    causeIn[i] <= 1'b1;
    repeat (5) @(posedge core_clk);
    causeIn[i] <= 1'b0;
    repeat (8) @(posedge core_clk);
    expFlags[i]    = 1'b1;
    expStat[26+i]  = 1'b1;
  endtask

  task automatic irq_is(input logic e);
    repeat (3) @(posedge core_clk);
    check_bit(irq, e);
  endtask

  function automatic logic [31:0] csts(input logic en);
    return {expFlags, 2'b00, 22'h00_0000, lsiStable, en};
  endfunction

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return (v >> 1) ^ (v[0] ? 32'h8020_0003 : 32'h0000_0000);
  endfunction

  // every completion pops one note; waits are counted while pready is low
  always @(posedge core_clk)
  begin
    if (psel === 1'b1 && penable === 1'b1 && pready !== 1'b1)
      waits++;
    else if (psel === 1'b1 && penable === 1'b1)
    begin
      mx = expQ.pop_front();
      if (pwrite !== 1'b1)
        check_word(prdata, mx.d);
      check_bit(pslverr, mx.e);
      check_bit(waits <= 3, 1'b1);
      if (mx.b2b)
        check_bit(waits > 0, 1'b1);
      waits = 0;
    end
  end

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    {srst, powerRst, psel, penable, pwrite, lsiStable, lastHold} = 7'h60;
    {paddr, pwdata, pstrb, causeIn} = '0;
    rnd = 32'h0000_0045;
    expStat = 32'h0000_0000;
    expFlags = 6'h03;
    repeat (10) @(posedge core_clk);
    srst     <= 1'b0;
    powerRst <= 1'b0;
    @(posedge core_clk);
    rd(rcsr_pkg::OFS_CSTS, csts(1'b0), 1'b0, 1'b0);
    wr(rcsr_pkg::OFS_CSTS, 32'h0000_0001, 4'h1, 1'b0);
    rd(rcsr_pkg::OFS_CSTS, csts(1'b1), 1'b0, 1'b0);
    check_bit(lsiOscEnable, 1'b1);
    wr(rcsr_pkg::OFS_CSTS, 32'h0000_0000, 4'h3, 1'b0);
    rd(rcsr_pkg::OFS_CSTS, csts(1'b0), 1'b0, 1'b0);
    check_bit(lsiOscEnable, 1'b0);
    // oscillator becomes stable: ready bit and its event
    lsiStable <= 1'b1;
    repeat (8) @(posedge core_clk);
    expStat[1] = 1'b1;
    rd(rcsr_pkg::OFS_CSTS, csts(1'b0), 1'b0, 1'b1);
    rd(rcsr_pkg::OFS_INT_STAT, expStat, 1'b0, 1'b0);
    irq_is(1'b0);
    wr(rcsr_pkg::OFS_INT_EN, 32'h0000_0002, 4'hf, 1'b0);
    rd(rcsr_pkg::OFS_INT_EN, 32'h0000_0002, 1'b0, 1'b0);
    irq_is(1'b1);
    wr(rcsr_pkg::OFS_INT_CLR, 32'h0000_0002, 4'hf, 1'b0);
    expStat = 32'h0000_0000;
    rd(rcsr_pkg::OFS_INT_CLR, 32'h0000_0000, 1'b0, 1'b0);
    irq_is(1'b0);
    wr(rcsr_pkg::OFS_INT_STAT, 32'hffff_ffff, 4'hf, 1'b0);
    rd(rcsr_pkg::OFS_INT_STAT, expStat, 1'b0, 1'b0);
    // cause bits written with one never set, reserved bits ignore writes
    wr(rcsr_pkg::OFS_CSTS, 32'hfeff_fffc, 4'hf, 1'b0);
    rd(rcsr_pkg::OFS_CSTS, csts(1'b0), 1'b0, 1'b0);
    wr(rcsr_pkg::OFS_CSTS, 32'h0100_0000, 4'h8, 1'b0);
    expFlags = 6'h00;
    rd(rcsr_pkg::OFS_CSTS, csts(1'b0), 1'b0, 1'b0);
    // every cause in turn, with its interrupt masked
    wr(rcsr_pkg::OFS_INT_EN, 32'h0000_0000, 4'hf, 1'b0);
    park();
    for (int i = 0; i < 6; i++)
    begin
      pulse(i);
      rd(rcsr_pkg::OFS_CSTS, csts(1'b0), 1'b0, 1'b0);
    end
    rd(rcsr_pkg::OFS_INT_STAT, expStat, 1'b0, 1'b0);
    irq_is(1'b0);
    wr(rcsr_pkg::OFS_INT_EN, 32'hfc00_0000, 4'hf, 1'b0);
    park();
    irq_is(1'b1);
    // system reset keeps the flags but drops the enable
    wr(rcsr_pkg::OFS_CSTS, 32'h0000_0001, 4'h1, 1'b0);
    park();
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    check_bit(lsiOscEnable, 1'b0);
    rd(rcsr_pkg::OFS_CSTS, csts(1'b0), 1'b0, 1'b0);
    irq_is(1'b0);
    // a software cause lands in the very cycle of a clear write and survives it
    causeIn[2] <= 1'b1;
    repeat (3) @(posedge core_clk);
    wr(rcsr_pkg::OFS_CSTS, 32'h0100_0000, 4'h8, 1'b0);
    causeIn[2] <= 1'b0;
    expFlags = 6'h04;
    rd(rcsr_pkg::OFS_CSTS, csts(1'b0), 1'b0, 1'b0);
    // power reset brings the flags back to pin and power
    powerRst <= 1'b1;
    repeat (2) @(posedge core_clk);
    powerRst <= 1'b0;
    repeat (8) @(posedge core_clk);
    expFlags = 6'h03;
    rd(rcsr_pkg::OFS_CSTS, csts(1'b0), 1'b0, 1'b0);
    // unmapped place refuses both directions
    wr(12'h100, 32'hffff_ffff, 4'hf, 1'b1);
    rd(12'h100, 32'h0000_0000, 1'b1, 1'b0);
    // random byte writes to the enable, each read back at once
    for (int k = 0; k < 8; k++)
    begin
      rnd = lfsr(rnd);
      wr(rcsr_pkg::OFS_CSTS, rnd, 4'h1, 1'b0);
      rd(rcsr_pkg::OFS_CSTS, csts(rnd[0]), 1'b0, k < 7);
    end
    stop_test();
  end
endmodule
